// [bridge_master_pkg.sv]
// Package: register map, field layout, command codes and carriers of the local-to-PCI master block
package bridge_master_pkg;

  // ************************************************************
  // Register offsets and reset values
  // ************************************************************
  localparam logic [7:0]  OFF_CFG_ADDR  = 8'h00;
  localparam logic [7:0]  OFF_CTRL      = 8'h04;
  localparam logic [7:0]  OFF_RANGE     = 8'h08;
  localparam logic [7:0]  OFF_IO_BASE   = 8'h0c;
  localparam logic [7:0]  OFF_CMD_WORD  = 8'h10;
  localparam logic [7:0]  OFF_STATUS    = 8'h14;
  localparam logic [31:0] RST_REG       = 32'h0000_0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          CFG_EN_BIT    = 31;
  localparam int          CTRL_MEM_EN   = 0;
  localparam int          CTRL_IO_EN    = 1;
  localparam int          CTRL_RA_EN    = 2;
  localparam int          CTRL_PF_LO    = 3;
  localparam int          CTRL_PCI_RD   = 4;
  localparam int          CTRL_PF_HI    = 12;
  localparam int          CMDW_MASTER   = 2;
  localparam logic [1:0]  PF_CONTINUOUS = 2'b00;
  localparam logic [1:0]  CFG_TYPE1     = 2'b01;
  localparam logic [4:0]  DEV_MAX       = 5'h14;

  // ************************************************************
  // PCI command codes and constants
  // ************************************************************
  localparam logic [3:0]  PCI_IO_RD     = 4'h2;
  localparam logic [3:0]  PCI_IO_WR     = 4'h3;
  localparam logic [3:0]  PCI_MEM_RD    = 4'h6;
  localparam logic [3:0]  PCI_MEM_WR    = 4'h7;
  localparam logic [3:0]  PCI_CFG_RD    = 4'ha;
  localparam logic [3:0]  PCI_CFG_WR    = 4'hb;
  localparam logic [3:0]  PCI_MEM_RD_M  = 4'hc;
  localparam logic [3:0]  BE_ALL_N      = 4'h0;
  localparam logic [31:0] LWORD_STEP    = 32'h0000_0004;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic        local_write_not_read;
    logic [3:0]  local_byte_enables_n;
    logic        burst;
    logic        last;
    logic [31:0] wdata;
  } local_req_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic        burst;
    logic [31:0] wdata;
  } pci_cmd_s;

  // Window decode: range holds the two's complement of a power-of-two size
  function automatic logic window_hit(input logic [31:0] addr, input logic [31:0] base,
                                      input logic [31:0] range);
    window_hit = ((addr ^ base) & range) == 32'h0000_0000;
  endfunction

  // Sequential Lword-aligned address that follows the one already fetched
  function automatic logic lword_next_hit(input logic [31:0] addr, input logic [31:0] expect_addr);
    lword_next_hit = (addr == expect_addr) && (addr[1:0] == 2'b00);
  endfunction

endpackage

// [cfg_addr_xlate.sv]
// Module: turns the configuration address register into a Type 0 or Type 1 PCI address
module cfg_addr_xlate
  import bridge_master_pkg::*;
(
  input  wire logic [31:0] config_cycle_address,
  output logic      [31:0] pci_addr
);

  logic [20:0] dev_sel;
  logic [4:0]  dev_num;

  assign dev_num = config_cycle_address[15:11];

  // ************************************************************
  // Address build
  // ************************************************************
  always_comb begin
    // Device numbers beyond the select field give no select at all
    dev_sel = (dev_num <= DEV_MAX) ? (21'h000001 << dev_num) : 21'h000000;
    if (config_cycle_address[1:0] == CFG_TYPE1) begin
      pci_addr = {8'h00, config_cycle_address[23:0]};
    end else begin
      pci_addr = {dev_sel, config_cycle_address[10:0]};
    end
  end

endmodule

// [read_ahead_track.sv]
// Module: open read stream tracker with one prefetched Lword held for the next sequential read
module read_ahead_track
  import bridge_master_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [31:0] start_addr,
  input  wire logic        close,
  input  wire logic        consume,
  input  wire logic        take_en,
  input  wire logic        pci_rvalid,
  input  wire logic [31:0] pci_rdata,
  output logic             rready,
  output logic             open,
  output logic      [31:0] next_addr,
  output logic             hold_valid,
  output logic      [31:0] hold_data
);

  logic        open_ff;
  logic        nxt_open;
  logic [31:0] next_addr_ff;
  logic [31:0] nxt_next_addr;
  logic        hold_valid_ff;
  logic        nxt_hold_valid;
  logic [31:0] hold_data_ff;
  logic [31:0] nxt_hold_data;
  logic        taken;

  // Only one word is held, so the PCI burst stalls on rready rather than overrunning
  assign rready     = open_ff && !hold_valid_ff && take_en;
  assign taken      = rready && pci_rvalid;
  assign open       = open_ff;
  assign next_addr  = next_addr_ff;
  assign hold_valid = hold_valid_ff;
  assign hold_data  = hold_data_ff;

  // ************************************************************
  // Stream state
  // ************************************************************
  always_comb begin
    nxt_open       = open_ff;
    nxt_next_addr  = next_addr_ff;
    nxt_hold_valid = hold_valid_ff;
    nxt_hold_data  = hold_data_ff;
    if (close) begin
      nxt_open       = 1'b0;
      nxt_hold_valid = 1'b0;
    end else if (start) begin
      nxt_open       = 1'b1;
      nxt_next_addr  = start_addr + LWORD_STEP;
      nxt_hold_valid = 1'b0;
    end else begin
      if (consume) begin
        nxt_next_addr  = next_addr_ff + LWORD_STEP;
        nxt_hold_valid = 1'b0;
      end
      if (taken) begin
        nxt_hold_valid = 1'b1;
        nxt_hold_data  = pci_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_ff       <= 1'b0;
      next_addr_ff  <= RST_REG;
      hold_valid_ff <= 1'b0;
      hold_data_ff  <= RST_REG;
    end else begin
      open_ff       <= nxt_open;
      next_addr_ff  <= nxt_next_addr;
      hold_valid_ff <= nxt_hold_valid;
      hold_data_ff  <= nxt_hold_data;
    end
  end

  AST_HOLD_NEEDS_OPEN : assert property (@(posedge pclk) disable iff (!presetn)
    hold_valid_ff |-> open_ff) else $error("held word without open stream");

endmodule

// [master_read_ahead_config_cycles.sv]
// Module: local-to-PCI master request path with read-ahead streaming and configuration cycles
module master_read_ahead_config_cycles
  import bridge_master_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              local_valid,
  input  wire local_req_s        local_req,
  output logic                   local_ready,
  output logic      [31:0]       local_rdata,
  output logic                   pci_cmd_valid,
  input  wire logic              pci_cmd_ready,
  output pci_cmd_s               pci_cmd,
  input  wire logic              pci_rvalid,
  input  wire logic [31:0]       pci_rdata,
  output logic                   pci_rready,
  output logic                   pci_stop
);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_RD_DATA, S_ACK} state_e;

  // ************************************************************
  // Register file over APB
  // ************************************************************
  logic [31:0] cfg_addr_ff;
  logic [31:0] nxt_cfg_addr;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] range_ff;
  logic [31:0] nxt_range;
  logic [31:0] io_base_ff;
  logic [31:0] nxt_io_base;
  logic [31:0] cmd_word_ff;
  logic [31:0] nxt_cmd_word;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        apb_wr;
  logic        mapped;
  logic [7:0]  reg_off;
  logic [31:0] status;

  state_e      state_ff;
  state_e      nxt_state;
  pci_cmd_s    cmd_ff;
  pci_cmd_s    nxt_cmd;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        wr_ff;
  logic        nxt_wr;
  logic        stream_ff;
  logic        nxt_stream;

  logic        ra_eff;
  logic        io_hit;
  logic        is_cfg;
  logic        is_mem;
  logic        wnr;
  logic        seq_hit;
  logic [31:0] cfg_pci_addr;
  pci_cmd_s    build;
  logic        trk_start;
  logic        trk_close;
  logic        trk_consume;
  logic        trk_rready;
  logic        trk_open;
  logic [31:0] trk_next;
  logic        trk_hold_valid;
  logic [31:0] trk_hold_data;

  assign reg_off = 8'(paddr);
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign mapped  = (reg_off == OFF_CFG_ADDR) || (reg_off == OFF_CTRL) || (reg_off == OFF_RANGE) ||
                   (reg_off == OFF_IO_BASE) || (reg_off == OFF_CMD_WORD) || (reg_off == OFF_STATUS);
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_ff;
  assign status  = {28'h0000000, (state_ff != S_IDLE), trk_hold_valid, trk_open, ra_eff};

  always_comb begin
    nxt_cfg_addr = cfg_addr_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_range    = range_ff;
    nxt_io_base  = io_base_ff;
    nxt_cmd_word = cmd_word_ff;
    nxt_prdata   = prdata_ff;
    if (apb_wr) begin
      unique case (reg_off)
        OFF_CFG_ADDR: nxt_cfg_addr = pwdata;
        OFF_CTRL:     nxt_ctrl     = pwdata;
        OFF_RANGE:    nxt_range    = pwdata;
        OFF_IO_BASE:  nxt_io_base  = pwdata;
        OFF_CMD_WORD: nxt_cmd_word = pwdata;
        default:      nxt_prdata   = prdata_ff;
      endcase
    end
    // Read data is captured in the setup cycle so the access phase answers with no wait
    if (psel && !penable && !pwrite) begin
      unique case (reg_off)
        OFF_CFG_ADDR: nxt_prdata = cfg_addr_ff;
        OFF_CTRL:     nxt_prdata = ctrl_ff;
        OFF_RANGE:    nxt_prdata = range_ff;
        OFF_IO_BASE:  nxt_prdata = io_base_ff;
        OFF_CMD_WORD: nxt_prdata = cmd_word_ff;
        OFF_STATUS:   nxt_prdata = status;
        default:      nxt_prdata = RST_REG;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_addr_ff <= RST_REG;
      ctrl_ff     <= RST_REG;
      range_ff    <= RST_REG;
      io_base_ff  <= RST_REG;
      cmd_word_ff <= RST_REG;
      prdata_ff   <= RST_REG;
    end else begin
      cfg_addr_ff <= nxt_cfg_addr;
      ctrl_ff     <= nxt_ctrl;
      range_ff    <= nxt_range;
      io_base_ff  <= nxt_io_base;
      cmd_word_ff <= nxt_cmd_word;
      prdata_ff   <= nxt_prdata;
    end
  end

  // ************************************************************
  // Request decode and command build
  // ************************************************************
  // Delayed read mode has no say here, so either setting of it leaves read-ahead unchanged
  assign ra_eff = ctrl_ff[CTRL_RA_EN] && ({ctrl_ff[CTRL_PF_HI], ctrl_ff[CTRL_PF_LO]} == PF_CONTINUOUS);
  assign io_hit = window_hit(local_req.addr, io_base_ff, range_ff);
  assign is_cfg = io_hit && cfg_addr_ff[CFG_EN_BIT];
  assign is_mem = !io_hit;
  assign wnr    = local_req.local_write_not_read;
  assign seq_hit = trk_open && is_mem && !wnr && lword_next_hit(local_req.addr, trk_next);

  cfg_addr_xlate u_xlate (
    .config_cycle_address (cfg_addr_ff),
    .pci_addr             (cfg_pci_addr)
  );

  always_comb begin
    build.addr  = is_cfg ? cfg_pci_addr : local_req.addr;
    build.wdata = local_req.wdata;
    build.burst = is_mem && (local_req.burst || (!wnr && ra_eff));
    build.be_n  = local_req.local_byte_enables_n;
    if (is_cfg) begin
      build.cmd = wnr ? PCI_CFG_WR : PCI_CFG_RD;
    end else if (io_hit) begin
      build.cmd = wnr ? PCI_IO_WR : PCI_IO_RD;
    end else if (wnr) begin
      build.cmd = PCI_MEM_WR;
    end else if (build.burst) begin
      build.cmd  = PCI_MEM_RD_M;
      build.be_n = BE_ALL_N;
    end else begin
      build.cmd = PCI_MEM_RD;
    end
  end

  // ************************************************************
  // Request sequencing
  // ************************************************************
  always_comb begin
    nxt_state   = state_ff;
    nxt_cmd     = cmd_ff;
    nxt_rdata   = rdata_ff;
    nxt_wr      = wr_ff;
    nxt_stream  = stream_ff;
    trk_start   = 1'b0;
    trk_close   = 1'b0;
    trk_consume = 1'b0;
    unique case (state_ff)
      S_IDLE: begin
        if (local_valid) begin
          if (trk_open && !seq_hit) begin
            // Out-of-order access or a write ends the open stream and drops its data
            trk_close = 1'b1;
          end else if (seq_hit && trk_hold_valid) begin
            nxt_rdata   = trk_hold_data;
            trk_consume = 1'b1;
            nxt_state   = S_ACK;
          end else if (seq_hit) begin
            nxt_stream = 1'b1;
            nxt_state  = S_RD_DATA;
          end else begin
            nxt_cmd    = build;
            nxt_wr     = wnr;
            nxt_stream = 1'b0;
            nxt_state  = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (pci_cmd_ready) begin
          // Posted writes sit in the write FIFO downstream, so the local cycle ends now
          nxt_state = wr_ff ? S_ACK : S_RD_DATA;
          trk_start = !wr_ff && cmd_ff.burst;
        end
      end
      S_RD_DATA: begin
        if (pci_rvalid) begin
          nxt_rdata   = pci_rdata;
          trk_consume = stream_ff;
          nxt_state   = S_ACK;
        end
      end
      S_ACK: begin
        // A non-continuous burst ends with the local burst; read-ahead keeps streaming
        if (!wr_ff && local_req.last && trk_open && !ra_eff) begin
          trk_close = 1'b1;
        end
        nxt_wr    = 1'b0;
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= S_IDLE;
      cmd_ff    <= '0;
      rdata_ff  <= RST_REG;
      wr_ff     <= 1'b0;
      stream_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cmd_ff    <= nxt_cmd;
      rdata_ff  <= nxt_rdata;
      wr_ff     <= nxt_wr;
      stream_ff <= nxt_stream;
    end
  end

  read_ahead_track u_track (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (trk_start),
    .start_addr (cmd_ff.addr),
    .close      (trk_close),
    .consume    (trk_consume),
    .take_en    (state_ff != S_RD_DATA),
    .pci_rvalid (pci_rvalid),
    .pci_rdata  (pci_rdata),
    .rready     (trk_rready),
    .open       (trk_open),
    .next_addr  (trk_next),
    .hold_valid (trk_hold_valid),
    .hold_data  (trk_hold_data)
  );

  assign pci_cmd_valid = (state_ff == S_ISSUE);
  assign pci_cmd       = cmd_ff;
  assign pci_rready    = (state_ff == S_RD_DATA) || trk_rready;
  assign pci_stop      = trk_close;
  assign local_ready   = (state_ff == S_ACK);
  assign local_rdata   = rdata_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_RA_FORCED_OFF : assert property (@(posedge pclk) disable iff (!presetn)
    ({ctrl_ff[CTRL_PF_HI], ctrl_ff[CTRL_PF_LO]} != PF_CONTINUOUS) |-> !ra_eff)
    else $error("read-ahead active without continuous prefetch");

  AST_SEQ_FROM_HOLD : assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_IDLE && local_valid && seq_hit && trk_hold_valid)
      |=> (local_ready && !pci_cmd_valid && local_rdata == $past(trk_hold_data)))
    else $error("sequential read did not return held word");

  AST_RA_SINGLE_BURST : assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_IDLE && local_valid && !trk_open && is_mem && !wnr && ra_eff)
      |=> (pci_cmd_valid && pci_cmd.burst && pci_cmd.be_n == BE_ALL_N && pci_cmd.cmd == PCI_MEM_RD_M))
    else $error("read-ahead single read not issued as full burst");

  AST_NONCONT_CLOSE : assert property (@(posedge pclk) disable iff (!presetn)
    (local_ready && !wr_ff && local_req.last && !ra_eff) |=> !trk_open)
    else $error("stream left open without continuous prefetch");

  AST_CFG_NO_PREFETCH : assert property (@(posedge pclk) disable iff (!presetn)
    (pci_cmd_valid && (pci_cmd.cmd == PCI_CFG_RD || pci_cmd.cmd == PCI_IO_RD))
      |-> (!pci_cmd.burst && !trk_open) ##1 !trk_open)
    else $error("configuration or I/O read prefetched");

  AST_CFG_CMD_DIR : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pci_cmd_valid) && $past(is_cfg) |-> pci_cmd.cmd == ($past(wnr) ? PCI_CFG_WR : PCI_CFG_RD))
    else $error("configuration command does not follow write-not-read");

  AST_TYPE0_ONEHOT : assert property (@(posedge pclk) disable iff (!presetn)
    (pci_cmd_valid && pci_cmd.cmd[3:1] == 3'b101 && cmd_ff.addr[1:0] != CFG_TYPE1)
      |-> $onehot0(pci_cmd.addr[31:11]))
    else $error("type 0 device select not one-hot");

  AST_TYPE1_TOP_ZERO : assert property (@(posedge pclk) disable iff (!presetn)
    (pci_cmd_valid && pci_cmd.cmd[3:1] == 3'b101 && pci_cmd.addr[1:0] == CFG_TYPE1)
      |-> pci_cmd.addr[31:24] == 8'h00)
    else $error("type 1 address top byte not zero");

  AST_WR_ACK_NOW : assert property (@(posedge pclk) disable iff (!presetn)
    (pci_cmd_valid && pci_cmd_ready && wr_ff) |=> local_ready)
    else $error("write not acknowledged after command taken");

  AST_RD_WAITS : assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_RD_DATA && !pci_rvalid) |=> !local_ready)
    else $error("read acknowledged before PCI data");

  AST_BE_FROM_LOCAL : assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == S_IDLE && local_valid && io_hit && !trk_open)
      |=> pci_cmd.be_n == $past(local_req.local_byte_enables_n))
    else $error("configuration or I/O byte enables not from local");

endmodule

// [pci_engine_model.sv]
// Partner model: PCI engine that takes commands and streams read words
module pci_engine_model
  import bridge_master_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        pci_cmd_valid,
  input  wire pci_cmd_s    pci_cmd,
  input  wire logic        pci_rready,
  input  wire logic        pci_stop,
  output logic             pci_cmd_ready,
  output logic             pci_rvalid,
  output logic      [31:0] pci_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] a;
  logic        strm;
  logic        tick;
  // Idle data lines toggle so a stale word never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pci_cmd_ready <= 1'b0;
      pci_rvalid    <= 1'b0;
      pci_rdata     <= 32'h0000_0000;
      strm          <= 1'b0;
      tick          <= 1'b0;
      a             <= 32'h0000_0000;
    end else begin
      tick          <= ~tick;
      pci_cmd_ready <= !slow || tick;
      if (pci_cmd_valid && pci_cmd_ready && !pci_cmd.cmd[0]) begin
        a          <= pci_cmd.addr;
        strm       <= pci_cmd.burst;
        pci_rvalid <= 1'b1;
        pci_rdata  <= {pci_cmd.addr[15:0], ~pci_cmd.addr[15:0]};
      end else if (pci_stop) begin
        pci_rvalid <= 1'b0;
        strm       <= 1'b0;
        pci_rdata  <= ~pci_rdata;
      end else if (pci_rvalid && pci_rready && strm) begin
        a         <= a + 32'h0000_0004;
        pci_rdata <= {a[15:0] + 16'h0004, ~(a[15:0] + 16'h0004)};
      end else if (pci_rvalid && pci_rready || !pci_rvalid) begin
        pci_rvalid <= 1'b0;
        pci_rdata  <= ~pci_rdata;
      end
    end
  end
endmodule

// [testbench.sv]
// Testbench: APB setup, local traffic and PCI command checks
module testbench;
  import bridge_master_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] amask;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic        burst;
  } exp_cmd_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
  logic        local_valid, local_ready, pci_cmd_valid, pci_cmd_ready, pci_rvalid, pci_rready, pci_stop;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, local_rdata, pci_rdata, rd, rv, cfg, ea;
  logic [4:0]  dev;
  logic [3:0]  be;
  local_req_s  local_req;
  pci_cmd_s    pci_cmd;
  exp_cmd_s    e;
  exp_cmd_s    cmd_q[$];
  logic [31:0] rd_q[$];
  int          miscompares, comparisons, i, stops;
  integer      seed = 32'h22e234b9;

  master_read_ahead_config_cycles #(.ADDR_W(8)) master_read_ahead_config_cycles_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .local_valid(local_valid), .local_req(local_req),
    .local_ready(local_ready), .local_rdata(local_rdata), .pci_cmd_valid(pci_cmd_valid),
    .pci_cmd_ready(pci_cmd_ready), .pci_cmd(pci_cmd), .pci_rvalid(pci_rvalid), .pci_rdata(pci_rdata),
    .pci_rready(pci_rready), .pci_stop(pci_stop));
  pci_engine_model pci_engine_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
    .pci_cmd_valid(pci_cmd_valid), .pci_cmd(pci_cmd), .pci_rready(pci_rready), .pci_stop(pci_stop),
    .pci_cmd_ready(pci_cmd_ready), .pci_rvalid(pci_rvalid), .pci_rdata(pci_rdata));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Request held whole until the acknowledge edge
  task automatic loc(input logic wr, input logic [31:0] ad, input logic bu);
    local_req   <= '{ad, wr, be, bu, 1'b1, rv};
    local_valid <= 1'b1;
    do @(posedge pclk); while (local_ready !== 1'b1);
    local_valid <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] word(input logic [31:0] a);
    word = {a[15:0], ~a[15:0]};
  endfunction
  task automatic exp(input logic [31:0] a, input logic [31:0] m, input logic [3:0] c, input logic [3:0] b,
                     input logic bu);
    cmd_q.push_back('{a, m, c, b, bu});
    if (!c[0]) rd_q.push_back(word(a));
  endtask

  // ****************************************
  // Monitor
  // ****************************************
  always @(posedge pclk) begin
    if (pci_cmd_valid === 1'b1 && pci_cmd_ready === 1'b1) begin
      if (cmd_q.size() == 0) check("spare pci command", 1, 0);
      else begin
        e = cmd_q.pop_front();
        check("pci addr", pci_cmd.addr & e.amask, e.addr & e.amask);
        check("pci cmd", pci_cmd.cmd, e.cmd);
        check("pci be", pci_cmd.be_n, e.be_n);
        check("pci burst", pci_cmd.burst, e.burst);
        if (e.cmd[0]) check("pci wdata", pci_cmd.wdata, local_req.wdata);
      end
    end
    if (pci_stop === 1'b1) stops++;
    if (local_ready === 1'b1 && local_req.local_write_not_read === 1'b0) begin
      if (rd_q.size() == 0) check("spare read", 1, 0);
      else check("local rdata", local_rdata, rd_q.pop_front());
    end
  end

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #200000;
    check("watchdog", 1, 0);
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, local_valid, slow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    local_req = '0;
    be = 4'h0;
    rv = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFF_CTRL, 0);
    check("ctrl reset", rd, RST_REG);
    rv = $random(seed);
    apb(1, OFF_CFG_ADDR, rv);
    apb(0, OFF_CFG_ADDR, 0);
    check("cfg readback", rd, rv);
    apb(0, 8'h20, 0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
    $display("test registers done");
    apb(1, OFF_CMD_WORD, 32'h0000_0004);
    apb(1, OFF_RANGE, 32'hfff0_0000);
    apb(1, OFF_IO_BASE, 32'h4000_0000);
    apb(1, OFF_CTRL, 32'h0000_0003);
    for (i = 0; i < 4; i++) begin
      rv = $random(seed);
      be = rv[3:0];
      dev = 5'({$random(seed)} % 21);
      cfg = {8'h80, rv[23:16], dev, rv[10:2], 1'b0, i[0]};
      ea = i[0] ? {8'h00, cfg[23:0]} : ((32'h0000_0800 << dev) | cfg[10:0]);
      apb(1, OFF_CFG_ADDR, cfg);
      exp(ea, 32'hffff_ffff, i[1] ? PCI_CFG_WR : PCI_CFG_RD, be, 1'b0);
      loc(i[1], 32'h4000_0000, i[0]);
    end
    apb(1, OFF_CFG_ADDR, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      be = 4'(i + 5);
      exp(32'h4000_0008, 32'hffff_ffff, i[0] ? PCI_IO_WR : PCI_IO_RD, be, 1'b0);
      loc(i[0], 32'h4000_0008, 1'b1);
    end
    $display("test configuration and io done");
    apb(1, OFF_CTRL, 32'h0000_0007);
    apb(0, OFF_STATUS, 0);
    check("ra effective", rd[0], 1);
    be = 4'h9;
    exp(32'h0000_1000, 32'hffff_ffff, PCI_MEM_RD_M, BE_ALL_N, 1'b1);
    rd_q.push_back(word(32'h0000_1004));
    loc(0, 32'h0000_1000, 1'b0);
    loc(0, 32'h0000_1004, 1'b0);
    exp(32'h0000_100c, 32'hffff_ffff, PCI_MEM_RD_M, BE_ALL_N, 1'b1);
    loc(0, 32'h0000_100c, 1'b0);
    exp(32'h0000_2000, 32'hffff_ffff, PCI_MEM_WR, be, 1'b0);
    loc(1, 32'h0000_2000, 1'b0);
    $display("test read ahead done");
    slow <= 1'b1;
    apb(1, OFF_CTRL, 32'h0000_1007);
    apb(0, OFF_STATUS, 0);
    check("ra forced off", rd[0], 0);
    exp(32'h0000_3000, 32'hffff_ffff, PCI_MEM_RD, be, 1'b0);
    exp(32'h0000_3004, 32'hffff_ffff, PCI_MEM_RD, be, 1'b0);
    exp(32'h0000_3008, 32'hffff_ffff, PCI_MEM_RD_M, BE_ALL_N, 1'b1);
    loc(0, 32'h0000_3000, 1'b0);
    loc(0, 32'h0000_3004, 1'b0);
    loc(0, 32'h0000_3008, 1'b1);
    repeat (4) @(posedge pclk);
    check("stream stops", stops, 3);
    check("pending commands", cmd_q.size(), 0);
    check("pending reads", rd_q.size(), 0);
    $display("test non continuous done");
    wrap_up();
  end
endmodule
